/* File: dv/inter_processor_link_bench.sv */
// self-checking bench: right-strapped board, behavioural left peer, bus master
// assumes link_pkg register map and a shortened watchdog limit
`timescale 1ns/1ps
`default_nettype none
module inter_processor_link_bench;
   import link_pkg::*;
   localparam int LIMIT = 50;
   logic        clk_i, arst_n_i, hwrite, mon_rd, strap, rdy_seen, irq, hresp, hrdyo, ob_d, ic_d;
   logic        oc_d, wr_p, sel_p, oc_p, id_p, nt_p, ob_p, ib_p, bt_p, bt_d, hsel, oe_d, ib_d, wr_d;
   logic [1:0]  htrans, cmd_p, hb_d, hb_p, hc_d;
   logic [2:0]  hsize;
   logic [15:0] w, w2, got, dat_p, dat_d, cab_w;
   logic [31:0] haddr, hwdata, hrdata;
   logic [31:0] want_q[$];
   int          checks, fails, wr_cyc, hd_cmds;

   link_board #(.WD_LIMIT(LIMIT)) u_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hrdyo), .hrdata_o(hrdata), .hreadyout_o(hrdyo), .hresp_o(hresp),
      .strap_left_i(strap), .link_data_i(dat_p), .link_data_o(dat_d),
      .link_data_oe_o(oe_d), .link_wr_i(wr_p), .link_wr_o(wr_d), .link_sel_i(sel_p),
      .link_sel_o(), .link_out_clr_i(oc_p), .link_out_clr_o(oc_d),
      .link_in_done_i(id_p), .link_in_done_o(ic_d), .link_hd_note_i(nt_p),
      .link_hd_note_o(), .link_out_busy_i(ob_p), .link_out_busy_o(ob_d),
      .link_in_busy_i(ib_p), .link_in_busy_o(ib_d), .link_hd_cmd_i(cmd_p),
      .link_hd_cmd_o(hc_d), .link_hd_busy_i(hb_p), .link_hd_busy_o(hb_d),
      .link_beat_i(bt_p), .link_beat_o(bt_d), .irq_o(irq));
   peer_board peer (
      .clk_i(clk_i), .data_i(dat_d), .in_done_i(ic_d), .out_clr_i(oc_d), .beat_i(bt_d),
      .data_o(dat_p), .wr_o(wr_p), .sel_o(sel_p), .out_clr_o(oc_p), .in_done_o(id_p),
      .hd_note_o(nt_p), .out_busy_o(ob_p), .in_busy_o(ib_p), .hd_cmd_o(cmd_p),
      .beat_o(bt_p));

   // 200 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks++;
      if (seen !== want)
      begin
         fails++;
         $display("wrong value at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ready as it will be sampled at the next rising edge, free of edge races
   always @(negedge clk_i) rdy_seen = hrdyo;
   // left-role cable activity, counted as the far board would see it
   always @(posedge clk_i)
   begin
      if (wr_d) wr_cyc <= wr_cyc + 1;
      if (wr_d && oe_d) cab_w <= dat_d;
      if (hc_d != 2'b00) hd_cmds <= hd_cmds + 1;
   end
   // oldest noted read value is compared when a read data phase completes
   always @(negedge clk_i)
   begin
      if (mon_rd && hrdyo === 1'b1) check(hrdata, want_q.pop_front());
   end
   // single word transfer; caller stands just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, a, wr, 3'h2};
      @(posedge clk_i);
      while (rdy_seen !== 1'b1) @(posedge clk_i);
      {hsel, htrans, hwdata, mon_rd} <= {1'b0, 2'h0, d, !wr};
      @(posedge clk_i);
      while (rdy_seen !== 1'b1) @(posedge clk_i);
      mon_rd <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      want_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input int b);
      xfer(1'b1, ADDR_CMD, 32'h1 << b);
   endtask
   // hang guard, well beyond the whole sequence
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
   initial
   begin
      {hsel, hsize, hb_p, htrans, haddr, hwrite, hwdata, mon_rd, strap, arst_n_i} = '0;
      {checks, fails, wr_cyc, hd_cmds} = '0;
      void'($urandom(32'hc92b));
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      // idle after reset: no flags, watchdog quiet while unarmed
      repeat (LIMIT + 10) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h0);
      check(irq, 1'b0);
      check(oe_d, 1'b1);
      rd(8'h20, 32'h0);
      // left to right, receiver armed before and then after the word arrives
      for (int k = 0; k < 2; k++)
      begin
         w = 16'($urandom);
         if (k == 0) cmd(CMD_IN_START);
         if (k == 0) rd(ADDR_STATUS, 32'h1);
         peer.send(1'b0, w);
         if (k == 1) cmd(CMD_IN_START);
         rd(ADDR_STATUS, 32'h3);
         check(irq, 1'b1);
         check(ib_d, 1'b1);
         rd(ADDR_FD_CLR, {16'h0, w});
         rd(ADDR_STATUS, 32'h0);
         check({peer.out_busy_o, peer.out_done}, 2'b01);
      end
      // both directions at once, each word kept in its own buffer
      w = 16'($urandom);
      w2 = 16'($urandom);
      peer.init_recv();
      cmd(CMD_IN_START);
      xfer(1'b1, ADDR_FD, {16'h0, w});
      peer.send(1'b0, w2);
      rd(ADDR_STATUS, 32'h7);
      check({ob_d, peer.in_done}, 2'b11);
      rd(ADDR_FD_CLR, {16'h0, w2});
      peer.fetch(1'b0, got);
      check(got, w);
      rd(ADDR_STATUS, 32'h8);
      cmd(CMD_OUT_CLEAR);
      rd(ADDR_STATUS, 32'h0);
      // interlocked link: right owns, then peer owns and our write is refused
      cmd(CMD_HD_CLAIM);
      peer.hd(2'b01);
      check(hb_d, 2'b10);
      rd(ADDR_STATUS, 32'h10);
      xfer(1'b1, ADDR_HD, {16'h0, w});
      peer.fetch(1'b1, got);
      check(got, w);
      cmd(CMD_HD_FREE);
      peer.hd(2'b01);
      check(hb_d, 2'b01);
      xfer(1'b1, ADDR_HD, {16'h0, ~w});
      peer.fetch(1'b1, got);
      check(got, w);
      peer.send(1'b1, w2);
      rd(ADDR_STATUS, 32'h60);
      rd(ADDR_HD, {16'h0, w2});
      peer.hd(2'b10);
      cmd(CMD_HD_DCLR);
      rd(ADDR_STATUS, 32'h0);
      // watchdog kept alive by peer beats, trips and disarms once they stop
      cmd(CMD_WD_KICK);
      cmd(CMD_WD_ARM);
      check(peer.beats, 32'h1);
      peer.beat(6);
      rd(ADDR_STATUS, 32'h80);
      repeat (LIMIT + 10) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h100);
      check(irq, 1'b1);
      xfer(1'b1, ADDR_CMD, 32'h280);
      rd(ADDR_STATUS, 32'h0);
      // role follows the strap; owner flags then come from the cable
      strap <= 1'b1;
      repeat (2) @(posedge clk_i);
      rd(ADDR_STATUS, 32'h200);
      hb_p <= 2'b01;
      rd(ADDR_STATUS, 32'h210);
      hb_p <= 2'b10;
      rd(ADDR_STATUS, 32'h240);
      hb_p <= 2'b00;
      // left board gates a written word straight onto the cable
      xfer(1'b1, ADDR_FD, {16'h0, w});
      cmd(CMD_HD_CLAIM);
      repeat (2) @(posedge clk_i);
      check(wr_cyc, 32'h2);
      check(cab_w, w);
      check(hd_cmds, 32'h1);
      check(hresp, 1'b0);
      report_and_stop();
   end
endmodule // inter_processor_link_bench
`default_nettype wire

/* File: dv/peer_board.sv */
// behavioural peer board at the left end of the cable: duplex flags, strobes, beats
// assumes the board under test is strapped right and shares its clock
`timescale 1ns/1ps
`default_nettype none
module peer_board
(
   input  wire logic        clk_i,
   input  wire logic [15:0] data_i,
   input  wire logic        in_done_i,
   input  wire logic        out_clr_i,
   input  wire logic        beat_i,
   output logic      [15:0] data_o,
   output logic             wr_o,
   output logic             sel_o,
   output logic             out_clr_o,
   output logic             in_done_o,
   output logic             hd_note_o,
   output logic             out_busy_o,
   output logic             in_busy_o,
   output logic      [1:0]  hd_cmd_o,
   output logic             beat_o
);
   logic hold;
   logic out_done;
   logic in_done;
   int   beats;
   initial
   begin
      {data_o, wr_o, sel_o, out_clr_o, in_done_o, hd_note_o, out_busy_o} = '0;
      {in_busy_o, hd_cmd_o, beat_o, hold, out_done, in_done} = '0;
      beats = 0;
   end
   // released data lines toggle every cycle so a stale word never looks valid
   always @(posedge clk_i)
   begin
      if (!hold) data_o <= ~data_o;
      if (beat_i) beats <= beats + 1;
      if (in_done_i && in_busy_o) in_done <= 1'b1;
      if (out_clr_i) {out_busy_o, out_done} <= {1'b0, out_busy_o};
   end
   // left write: strobe two cycles, word in the second, then the notify pulse
   task automatic send(input logic s, input logic [15:0] w);
      @(posedge clk_i);
      {wr_o, sel_o, hold} <= {1'b1, s, 1'b1};
      @(posedge clk_i);
      data_o <= w;
      @(posedge clk_i);
      {wr_o, hold} <= 2'b00;
      if (s) hd_note_o <= 1'b1;
      else {in_done_o, out_busy_o, out_done} <= 3'b110;
      @(posedge clk_i);
      {hd_note_o, in_done_o} <= 2'b00;
   endtask
   // arm the local receiver
   task automatic init_recv();
      @(posedge clk_i);
      {in_busy_o, in_done} <= 2'b10;
   endtask
   // pick a stored word off the right board; duplex reads also release the sender
   task automatic fetch(input logic s, output logic [15:0] w);
      @(posedge clk_i);
      sel_o <= s;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      w = data_i;
      @(posedge clk_i);
      if (!s) {out_clr_o, in_busy_o, in_done} <= 3'b100;
      @(posedge clk_i);
      out_clr_o <= 1'b0;
   endtask
   // interlock request pulse: bit0 claim, bit1 release
   task automatic hd(input logic [1:0] c);
      @(posedge clk_i);
      hd_cmd_o <= c;
      @(posedge clk_i);
      hd_cmd_o <= 2'b00;
      repeat (2) @(posedge clk_i);
   endtask
   // heartbeat every 20 cycles
   task automatic beat(input int n);
      repeat (n)
      begin
         repeat (19) @(posedge clk_i);
         beat_o <= 1'b1;
         @(posedge clk_i);
         beat_o <= 1'b0;
      end
   endtask
endmodule // peer_board
`default_nettype wire

/* File: shared/flag_if.sv */
// busy/done flag pair controls between the board top and its flag units
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface flag_if;
   logic busy_set;
   logic busy_clr;
   logic done_set;
   logic done_clr;
   logic busy;
   logic done;
   modport ctl  (output busy_set, busy_clr, done_set, done_clr, input busy, done);
   modport unit (input busy_set, busy_clr, done_set, done_clr, output busy, done);
endinterface
`default_nettype wire

/* File: shared/link_pkg.sv */
// constants for the processor link board: register map, command bits, timing
// assumes a 200 MHz system clock
package link_pkg;
   localparam logic [7:0] ADDR_CMD     = 8'h00;
   localparam logic [7:0] ADDR_FD      = 8'h04;
   localparam logic [7:0] ADDR_FD_CLR  = 8'h08;
   localparam logic [7:0] ADDR_HD      = 8'h0c;
   localparam logic [7:0] ADDR_STATUS  = 8'h10;
   // command register bit positions
   localparam int CMD_IN_START  = 0;
   localparam int CMD_IN_CLEAR  = 1;
   localparam int CMD_OUT_CLEAR = 2;
   localparam int CMD_HD_CLAIM  = 3;
   localparam int CMD_HD_FREE   = 4;
   localparam int CMD_HD_DCLR   = 5;
   localparam int CMD_WD_ARM    = 6;
   localparam int CMD_WD_STOP   = 7;
   localparam int CMD_WD_KICK   = 8;
   localparam int CMD_WD_DCLR   = 9;
   localparam int WORD_W        = 16;
   localparam logic [1:0] WAIT_CYC = 2'h2;
   localparam logic [15:0] WORD_RST = 16'h0000;
   // watchdog interval
   localparam real WD_TIME_S    = 1.0;
   localparam real CLK_HZ       = 200.0e6;
   localparam int  WD_CYCLES    = int'(WD_TIME_S * CLK_HZ);
endpackage

/* File: src/flag_unit.sv */
// one busy flag and one done flag; a set beats a clear in the same cycle
// assumes controls are single-cycle pulses from the board top
`timescale 1ns/1ps
`default_nettype none
module flag_unit
(
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   flag_if.unit      f
);
   logic busy_q;
   logic done_q;
   logic next_busy;
   logic next_done;

   // set has priority so an event meeting a clear is kept
   always_comb
   begin
      next_busy = f.busy_set ? 1'b1 : (f.busy_clr ? 1'b0 : busy_q);
      next_done = f.done_set ? 1'b1 : (f.done_clr ? 1'b0 : done_q);
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         busy_q <= next_busy;
         done_q <= next_done;
      end
   end

   assign f.busy = busy_q;
   assign f.done = done_q;
endmodule // flag_unit
`default_nettype wire

/* File: src/link_board.sv */
// processor link board: duplex word links, interlocked link, watchdog
// assumes the peer board runs on the same clock; cable inputs are synchronous
// Operation
// - four units: duplex sender, duplex receiver, interlocked link, watchdog; 16-bit
// - words go host bus, cable data lines, then peer host bus
// - each sender and receiver has its own 16-bit buffer
// - every unit has its own busy and done flag
// - flags react to both hosts' commands and both boards' flags
// - host sees status by interrupt and by reading flags
// - left or right role comes from a cable strap
// - all words are stored on the right board; left only gates
// - right buffers split by link type and direction
// - left board's own duplex buffering is off
// - right board holds interlocked busy flags for both hosts
// - role is visible to software in status bit 9
// - watchdog times one second and interrupts the surviving host
// - watchdog reports peer hardware or software failure
// - only one host owns the interlocked link at a time
// - duplex pair carries independent traffic both ways
// - initiate receive: busy 1, done 0; done rises when peer sending
// - read with clear zeroes input flags, releases peer sender
// - write start: out busy 1, done 0; peer input done set
`timescale 1ns/1ps
`default_nettype none
module link_board
   import link_pkg::*;
#(
   parameter int WD_LIMIT = link_pkg::WD_CYCLES
)
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        strap_left_i,
   input  wire logic [15:0] link_data_i,
   output logic      [15:0] link_data_o,
   output logic             link_data_oe_o,
   input  wire logic        link_wr_i,
   output logic             link_wr_o,
   input  wire logic        link_sel_i,
   output logic             link_sel_o,
   input  wire logic        link_out_clr_i,
   output logic             link_out_clr_o,
   input  wire logic        link_in_done_i,
   output logic             link_in_done_o,
   input  wire logic        link_hd_note_i,
   output logic             link_hd_note_o,
   input  wire logic        link_out_busy_i,
   output logic             link_out_busy_o,
   input  wire logic        link_in_busy_i,
   output logic             link_in_busy_o,
   input  wire logic [1:0]  link_hd_cmd_i,
   output logic      [1:0]  link_hd_cmd_o,
   input  wire logic [1:0]  link_hd_busy_i,
   output logic      [1:0]  link_hd_busy_o,
   input  wire logic        link_beat_i,
   output logic             link_beat_o,
   output logic             irq_o
);
   import link_pkg::*;

   flag_if fin ();
   flag_if fout ();
   flag_if fhd ();
   flag_if fwd ();

   logic        wd_expire;
   logic        role_left;
   logic        ph_act, ph_wr, next_act, next_wr;
   logic [7:0]  ph_addr, next_addr;
   logic [1:0]  ph_cnt, next_cnt;
   logic        do_wr, do_rd;
   logic [15:0] rx_fd, tx_fd, rx_hd, tx_hd;
   logic [15:0] next_rx_fd, next_tx_fd, next_rx_hd, next_tx_hd;
   logic        wr_seen;
   logic [1:0]  lw_cnt, next_lw_cnt;
   logic        lw_hd, next_lw_hd;
   logic [1:0]  hd_own, next_hd_own;
   logic [15:0] cmd;
   logic        hd_mine;
   logic [15:0] rd_word;
   logic [31:0] next_rdata;

   flag_unit u_in   (.clk_i(clk_i), .arst_n_i(arst_n_i), .f(fin));
   flag_unit u_out  (.clk_i(clk_i), .arst_n_i(arst_n_i), .f(fout));
   flag_unit u_hd   (.clk_i(clk_i), .arst_n_i(arst_n_i), .f(fhd));
   flag_unit u_wd   (.clk_i(clk_i), .arst_n_i(arst_n_i), .f(fwd));

   // watchdog counts only while its busy flag says armed
   wd_timer #(.LIMIT(WD_LIMIT)) u_wdt
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .armed_i  (fwd.busy),
      .kick_i   (link_beat_i),
      .expire_o (wd_expire)
   );

   // bus front end: fixed wait so a left board sees the right board's word
   always_comb
   begin
      next_act  = ph_act;
      next_wr   = ph_wr;
      next_addr = ph_addr;
      next_cnt  = ph_cnt;
      if (ph_act && ph_cnt != 2'h0)
         next_cnt = ph_cnt - 2'h1;
      else if (hsel_i && htrans_i[1] && hready_i)
      begin
         next_act  = 1'b1;
         next_wr   = hwrite_i;
         next_addr = haddr_i[7:0];
         next_cnt  = WAIT_CYC;
      end
      else
         next_act = 1'b0;
   end

   assign do_wr = ph_act && ph_cnt == 2'h1 && ph_wr;
   assign do_rd = ph_act && ph_cnt == 2'h1 && !ph_wr;
   assign cmd   = do_wr && ph_addr == ADDR_CMD ? hwdata_i[15:0] : 16'h0000;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ph_act      <= 1'b0;
         ph_wr       <= 1'b0;
         ph_addr     <= 8'h00;
         ph_cnt      <= 2'h0;
         hreadyout_o <= 1'b1;
         hrdata_o    <= 32'h0000_0000;
         role_left   <= 1'b0;
         hresp_o     <= 1'b0;
      end
      else
      begin
         ph_act      <= next_act;
         ph_wr       <= next_wr;
         ph_addr     <= next_addr;
         ph_cnt      <= next_cnt;
         hreadyout_o <= !(next_act && next_cnt != 2'h0);
         hrdata_o    <= next_rdata;
         role_left   <= strap_left_i;
         hresp_o     <= 1'b0; // every answer is OKAY
      end
   end

   // left reads the cable, right reads its own buffers; same map for both
   always_comb
   begin
      rd_word = 16'h0000;
      case (ph_addr)
         ADDR_FD, ADDR_FD_CLR: rd_word = role_left ? link_data_i : rx_fd;
         ADDR_HD:              rd_word = role_left ? link_data_i : rx_hd;
         ADDR_STATUS:          rd_word = {6'h00, role_left, fwd.done, fwd.busy,
                                          !hd_mine && (role_left ? |link_hd_busy_i : |hd_own),
                                          fhd.done, hd_mine, fout.done, fout.busy,
                                          fin.done, fin.busy};
         default:              rd_word = 16'h0000;
      endcase
      next_rdata = do_rd ? {16'h0000, rd_word} : hrdata_o;
   end

   assign hd_mine = role_left ? link_hd_busy_i[0] : hd_own[1];

   // flag controls: local commands, the peer's pulses and levels, watchdog expiry
   always_comb
   begin
      fin.busy_set  = cmd[CMD_IN_START];
      fin.busy_clr  = cmd[CMD_IN_CLEAR] || (do_rd && ph_addr == ADDR_FD_CLR);
      fin.done_set  = (fin.busy && link_out_busy_i && !fin.busy_clr)
                      || (fin.busy && link_in_done_i);
      fin.done_clr  = fin.busy_set || fin.busy_clr;
      fout.busy_set = do_wr && ph_addr == ADDR_FD;
      fout.busy_clr = cmd[CMD_OUT_CLEAR] || link_out_clr_i;
      fout.done_set = link_out_clr_i && fout.busy;
      fout.done_clr = fout.busy_set || cmd[CMD_OUT_CLEAR] || link_out_clr_i;
      fhd.busy_set  = 1'b0;
      fhd.busy_clr  = 1'b0;
      fhd.done_set  = link_hd_note_i;
      fhd.done_clr  = cmd[CMD_HD_DCLR];
      fwd.busy_set  = cmd[CMD_WD_ARM];
      fwd.busy_clr  = cmd[CMD_WD_STOP] || wd_expire;
      fwd.done_set  = wd_expire;
      fwd.done_clr  = cmd[CMD_WD_DCLR];
   end

   // right-board buffers; left drives cable words in a two-cycle strobe
   always_comb
   begin
      next_rx_fd  = rx_fd;
      next_tx_fd  = tx_fd;
      next_rx_hd  = rx_hd;
      next_tx_hd  = tx_hd;
      next_lw_cnt = lw_cnt == 2'h0 ? 2'h0 : lw_cnt - 2'h1;
      next_lw_hd  = lw_hd;
      if (!role_left && link_wr_i && wr_seen)
      begin
         if (link_sel_i)
            next_rx_hd = link_data_i;
         else
            next_rx_fd = link_data_i;
      end
      if (do_wr && (ph_addr == ADDR_FD || (ph_addr == ADDR_HD && hd_mine)))
      begin
         if (role_left)
         begin
            next_lw_cnt = 2'h2;
            next_lw_hd  = ph_addr == ADDR_HD;
         end
         else if (ph_addr == ADDR_HD)
            next_tx_hd = hwdata_i[15:0];
         else
            next_tx_fd = hwdata_i[15:0];
      end
   end

   // interlocked ownership lives on the right board only
   always_comb
   begin
      next_hd_own = hd_own;
      if (!role_left)
      begin
         if (cmd[CMD_HD_CLAIM] && !hd_own[0])
            next_hd_own[1] = 1'b1;
         else if (link_hd_cmd_i[0] && !hd_own[1])
            next_hd_own[0] = 1'b1;
         if (cmd[CMD_HD_FREE])
            next_hd_own[1] = 1'b0;
         if (link_hd_cmd_i[1])
            next_hd_own[0] = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rx_fd <= WORD_RST;
         tx_fd <= WORD_RST;
         rx_hd <= WORD_RST;
         tx_hd <= WORD_RST;
         lw_cnt <= 2'h0;
         lw_hd <= 1'b0;
         hd_own <= 2'h0;
         wr_seen <= 1'b0;
      end
      else
      begin
         rx_fd <= next_rx_fd;
         tx_fd <= next_tx_fd;
         rx_hd <= next_rx_hd;
         tx_hd <= next_tx_hd;
         lw_cnt <= next_lw_cnt;
         lw_hd <= next_lw_hd;
         hd_own <= next_hd_own;
         wr_seen <= link_wr_i;
      end
   end

   // cable outputs, all registered; right drives unless left is writing
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         link_data_o     <= WORD_RST;
         link_data_oe_o  <= 1'b0;
         link_wr_o       <= 1'b0;
         link_sel_o      <= 1'b0;
         link_out_clr_o  <= 1'b0;
         link_in_done_o  <= 1'b0;
         link_hd_note_o  <= 1'b0;
         link_out_busy_o <= 1'b0;
         link_in_busy_o  <= 1'b0;
         link_hd_cmd_o   <= 2'h0;
         link_hd_busy_o  <= 2'h0;
         link_beat_o     <= 1'b0;
         irq_o           <= 1'b0;
      end
      else
      begin
         if (role_left)
         begin
            link_data_o    <= do_wr ? hwdata_i[15:0] : link_data_o;
            link_data_oe_o <= lw_cnt == 2'h2;
            link_wr_o      <= next_lw_cnt != 2'h0;
            link_sel_o     <= (next_act && next_cnt == WAIT_CYC) ? next_addr == ADDR_HD
                              : (next_lw_cnt != 2'h0 ? next_lw_hd : link_sel_o);
         end
         else
         begin
            link_data_o    <= link_sel_i ? tx_hd : tx_fd;
            link_data_oe_o <= !link_wr_i;
            link_wr_o      <= 1'b0;
            link_sel_o     <= 1'b0;
         end
         link_out_clr_o  <= fin.busy_clr || (fin.busy_set && fin.busy);
         link_in_done_o  <= fout.busy_set;
         link_hd_note_o  <= do_wr && ph_addr == ADDR_HD && hd_mine;
         link_out_busy_o <= next_out_busy();
         link_in_busy_o  <= fin.busy;
         link_hd_cmd_o   <= role_left ? {cmd[CMD_HD_FREE], cmd[CMD_HD_CLAIM]} : 2'h0;
         link_hd_busy_o  <= role_left ? 2'h0 : {hd_own[1], hd_own[0]};
         link_beat_o     <= cmd[CMD_WD_KICK];
         irq_o           <= fin.done || fout.done || fhd.done || fwd.done;
      end
   end

   function automatic logic next_out_busy();
      next_out_busy = fout.busy_set || (fout.busy && !fout.busy_clr);
   endfunction

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_start_sets_busy: assert property (fin.busy_set |=> fin.busy && !fin.done)
      else $error("receive start did not set busy");
   a_done_follows: assert property (fin.busy && !fin.busy_clr && !fin.busy_set
      && link_out_busy_i |=> fin.done)
      else $error("input done missed peer sender");
   a_clear_input: assert property (fin.busy_clr && !fin.busy_set
      |=> !fin.busy && !fin.done && link_out_clr_o)
      else $error("read clear failed");
   a_peer_release: assert property (link_out_clr_i && !fout.busy_set
      |=> !fout.busy && fout.done == $past(fout.busy))
      else $error("peer release wrong");
   a_write_start: assert property (fout.busy_set |=> fout.busy && link_in_done_o)
      else $error("write start wrong");
   a_hd_single: assert property (!(hd_own[0] && hd_own[1]))
      else $error("two owners of interlocked link");
   a_left_no_own: assert property (role_left |-> link_hd_busy_o == 2'h0)
      else $error("left board drives owner flags");
   a_wd_fires: assert property (wd_expire |=> fwd.done && !fwd.busy ##1 irq_o)
      else $error("watchdog did not interrupt");
   a_bus_wait: assert property (hsel_i && htrans_i[1] && hready_i && hreadyout_o
      |=> !hreadyout_o [*2] ##1 hreadyout_o)
      else $error("bus answer timing wrong");
   a_no_clash: assert property (!role_left && link_wr_i |=> !link_data_oe_o)
      else $error("right drives during left write");

   c_fd_round: cover property (fin.done ##[1:20] fout.done);
   c_hd_claim: cover property ($rose(hd_own[1]));
   c_wd_expire: cover property (wd_expire);
   c_left_write: cover property (role_left && link_wr_o);
endmodule // link_board
`default_nettype wire

/* File: src/wd_timer.sv */
// watchdog counter: expires when armed and no peer heartbeat within the limit
// assumes kick is a pulse from the peer board
`timescale 1ns/1ps
`default_nettype none
module wd_timer
#(
   parameter int LIMIT = 200000000
)
(
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic armed_i,
   input  wire logic kick_i,
   output logic      expire_o
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        next_exp;

   // counter restarts on every heartbeat and while disarmed
   always_comb
   begin
      next_exp = 1'b0;
      next_cnt = cnt;
      if (!armed_i || kick_i)
         next_cnt = 32'h0000_0000;
      else if (cnt == 32'(LIMIT - 1))
      begin
         next_exp = 1'b1;
         next_cnt = 32'h0000_0000;
      end
      else
         next_cnt = cnt + 32'h0000_0001;
   end

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cnt      <= 32'h0000_0000;
         expire_o <= 1'b0;
      end
      else
      begin
         cnt      <= next_cnt;
         expire_o <= next_exp;
      end
   end
endmodule // wd_timer
`default_nettype wire
